// File: core/eisa_line_sync.sv
`timescale 1ns/1ns
module eisa_line_sync
    import eisa_pkg::*;
#(
    parameter int W = 5
) (
    input wire logic clk_sys,
    eisa_sync_if.sync sif
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } eisa_sync_state_t;

    eisa_sync_state_t s_r;
    eisa_sync_state_t s_nxt;

    // ************************************************************
    // two-stage synchroniser
    // ************************************************************
    // the first stage feeds only the second; a line missing setup
    // may show up one cycle late, which the pending flags absorb
    always_comb begin
        s_nxt        = s_r;
        s_nxt.meta   = sif.raw;
        s_nxt.stable = s_r.meta;
    end

    // lines idle high, so reset to the inactive level
    always_ff @(posedge clk_sys) begin
        if (!sif.rst_b) begin
            s_r <= '1;
        end else if (sif.clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign sif.synced = s_r.stable;
endmodule

// File: core/eisa_pkg.sv
package eisa_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int EISA_NUM_LINES = 4;
    localparam int EISA_WS_W      = 3;
    localparam int EISA_CNT_W     = 2;
    localparam int EISA_SYNC_W    = EISA_NUM_LINES + 1;

    // ************************************************************
    // reset values and counts
    // ************************************************************
    // wait states of a slow external access and of the boot vector
    localparam logic [EISA_WS_W-1:0]  EISA_WS_RESET     = 3'h7;
    localparam logic [EISA_WS_W-1:0]  EISA_WS_NONE      = 3'h0;
    // the reset vector is read this many times
    localparam logic [EISA_CNT_W-1:0] EISA_VEC_FETCHES  = 2'h2;
    // cycles after reset release before the mode pin is trusted;
    // the synchroniser still shows its reset value at the second edge
    localparam logic [EISA_CNT_W-1:0] EISA_SETTLE_CYCLES = 2'h3;
    // position of the mode pin in the synchroniser word
    localparam int EISA_MODE_BIT = EISA_NUM_LINES;
    localparam logic EISA_ACK_IDLE = 1'h1;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        EISA_ST_SETTLE,
        EISA_ST_FETCH,
        EISA_ST_RUN
    } eisa_boot_t;

    typedef enum logic {
        EISA_SEL_PRIMARY,
        EISA_SEL_EXPANSION
    } eisa_bus_sel_t;

endpackage

// File: core/eisa_sync_if.sv
`timescale 1ns/1ns
interface eisa_sync_if #(
    parameter int W = 5
) (
    input wire logic clk_sys
);
    logic         rst_b;
    logic         clk_en;
    logic [W-1:0] raw;
    logic [W-1:0] synced;

    modport owner (output rst_b, output clk_en, output raw, input synced);
    modport sync  (input rst_b, input clk_en, input raw, output synced);
endinterface

// File: core/eisa_top.sv
`timescale 1ns/1ns
// Operation
// R1: processor mode: reset vector read twice, seven wait states each read.
// R2: microcomputer mode: reset vector read twice, no wait states.
// R3: reset sets primary and expansion bus wait states to seven.
// R4: interrupt lines are level sensitive; a low level requests.
// R5: lines are sampled on every falling edge of clock phase one.
// R6: core and dma take interrupts only at instruction fetch boundaries.
// R7: source holds its line one to two sampling edges for one interrupt.
// R8: same source accepted at most once per two cycles.
// R9: a late line may be seen one cycle later; this is tolerated.
// R10: acknowledge strobe goes low when the ack instruction enters decode.
// R11: acknowledge strobe returns high when the ack instruction enters read.
// R12: detection sets a pending flag, cleared only when taken.
module eisa_top
    import eisa_pkg::*;
#(
    parameter int NUM_LINES = EISA_NUM_LINES
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    input  wire logic                 clk_en,
    input  wire logic [NUM_LINES-1:0] external_interrupt_lines_b,
    input  wire logic                 mode_microcomputer,
    input  wire logic                 fetch_boundary,
    input  wire logic [NUM_LINES-1:0] cpu_int_enable,
    input  wire logic [NUM_LINES-1:0] dma_int_enable,
    output logic      [NUM_LINES-1:0] cpu_take,
    output logic      [NUM_LINES-1:0] dma_take,
    output logic      [NUM_LINES-1:0] pending,
    input  wire logic                 ack_decode_start,
    input  wire logic                 ack_read_start,
    output logic                      interrupt_ack_strobe_b,
    output logic                      vec_fetch_req,
    output logic      [EISA_WS_W-1:0] vec_fetch_waits,
    input  wire logic                 vec_fetch_done,
    output logic                      boot_done,
    input  wire logic                 wait_cfg_we,
    input  wire logic                 wait_cfg_sel,
    input  wire logic [EISA_WS_W-1:0] wait_cfg_data,
    output logic      [EISA_WS_W-1:0] wait_primary,
    output logic      [EISA_WS_W-1:0] wait_expansion
);

    typedef struct packed {
        eisa_boot_t              boot;
        logic [EISA_CNT_W-1:0]   cnt;
        logic                    micro;
        logic [EISA_WS_W-1:0]    vec_waits;
        logic [EISA_WS_W-1:0]    ws_pri;
        logic [EISA_WS_W-1:0]    ws_exp;
        logic [NUM_LINES-1:0]    holdoff;
        logic [NUM_LINES-1:0]    pend;
        logic                    ack_b;
    } eisa_state_t;

    eisa_state_t s_r;
    eisa_state_t s_nxt;

    logic [NUM_LINES-1:0] det;
    logic [NUM_LINES-1:0] take_vec;
    logic [NUM_LINES:0]   synced_w;
    logic                 run;

    function automatic logic [NUM_LINES-1:0] eisa_lowest(
        input logic [NUM_LINES-1:0] v
    );
        eisa_lowest = v & (~v + {{(NUM_LINES-1){1'b0}}, 1'b1});
    endfunction

    // ************************************************************
    // pin synchroniser
    // ************************************************************
    eisa_sync_if #(.W(NUM_LINES + 1)) sif (.clk_sys(clk_sys));

    assign sif.rst_b  = rst_b;
    assign sif.clk_en = clk_en;
    assign sif.raw    = {mode_microcomputer, external_interrupt_lines_b};
    assign synced_w   = sif.synced;

    eisa_line_sync #(.W(NUM_LINES + 1)) u_sync (
        .clk_sys (clk_sys),
        .sif     (sif)
    );

    // ************************************************************
    // detection and take
    // ************************************************************
    // every clk_sys edge with clk_en high stands for one falling edge of clock phase one
    // a low level detects unless the line detected on the edge before,
    // so a pulse over two edges yields one request
    assign det = ~synced_w[NUM_LINES-1:0] & ~s_r.holdoff;  // R4 R5 R8

    assign run = (s_r.boot == EISA_ST_RUN);

    // the core is served first; the dma picks from what is left
    always_comb begin
        cpu_take = '0;
        dma_take = '0;
        if (run && fetch_boundary) begin  // R6
            cpu_take = eisa_lowest(s_r.pend & cpu_int_enable);
            dma_take = eisa_lowest(s_r.pend & dma_int_enable & ~cpu_take);
        end
    end

    assign take_vec = cpu_take | dma_take;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_nxt         = s_r;
        s_nxt.holdoff = det;  // R8
        // a detection in the cycle of its take wins over the clear
        s_nxt.pend    = (s_r.pend & ~take_vec) | det;  // R12 R9

        // decode of a following ack instruction keeps the strobe low
        if (ack_decode_start) begin
            s_nxt.ack_b = 1'b0;  // R10
        end else if (ack_read_start) begin
            s_nxt.ack_b = 1'b1;  // R11
        end

        if (wait_cfg_we) begin
            if (wait_cfg_sel == EISA_SEL_EXPANSION) begin
                s_nxt.ws_exp = wait_cfg_data;
            end else begin
                s_nxt.ws_pri = wait_cfg_data;
            end
        end

        case (s_r.boot)
            EISA_ST_SETTLE: begin
                s_nxt.cnt = s_r.cnt + 2'h1;
                if (s_r.cnt == EISA_SETTLE_CYCLES - 2'h1) begin
                    // mode strap caught once the synchroniser is full
                    s_nxt.micro = synced_w[EISA_MODE_BIT];
                    s_nxt.vec_waits = synced_w[EISA_MODE_BIT] ?
                                      EISA_WS_NONE :   // R2
                                      EISA_WS_RESET;   // R1
                    s_nxt.cnt  = '0;
                    s_nxt.boot = EISA_ST_FETCH;
                end
            end
            EISA_ST_FETCH: begin
                if (vec_fetch_done) begin
                    s_nxt.cnt = s_r.cnt + 2'h1;
                    if (s_r.cnt == EISA_VEC_FETCHES - 2'h1) begin  // R1 R2
                        s_nxt.cnt  = '0;
                        s_nxt.boot = EISA_ST_RUN;
                    end
                end
            end
            EISA_ST_RUN: begin
                s_nxt.cnt = '0;
            end
            default: begin
                s_nxt.boot = EISA_ST_SETTLE;
            end
        endcase
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_r           <= '0;
            s_r.boot      <= EISA_ST_SETTLE;
            s_r.vec_waits <= EISA_WS_RESET;
            s_r.ws_pri    <= EISA_WS_RESET;  // R3
            s_r.ws_exp    <= EISA_WS_RESET;  // R3
            s_r.ack_b     <= EISA_ACK_IDLE;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign pending                = s_r.pend;
    assign interrupt_ack_strobe_b = s_r.ack_b;
    assign vec_fetch_req          = (s_r.boot == EISA_ST_FETCH);
    assign vec_fetch_waits        = s_r.vec_waits;
    assign boot_done              = run;
    assign wait_primary           = s_r.ws_pri;
    assign wait_expansion         = s_r.ws_exp;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b || !clk_en);

    property p_r1;
        vec_fetch_req && !s_r.micro |-> vec_fetch_waits == 3'h7;
    endproperty
    a_r1: assert property (p_r1)  // R1
        else $error("boot fetch in processor mode lacks seven waits");

    property p_r2;
        vec_fetch_req && s_r.micro |-> vec_fetch_waits == 3'h0;
    endproperty
    a_r2: assert property (p_r2)  // R2
        else $error("boot fetch in microcomputer mode has waits");

    property p_r2_count;
        vec_fetch_req && vec_fetch_done && s_r.cnt == 2'h1 |=> boot_done;
    endproperty
    a_r2_count: assert property (p_r2_count)  // R2
        else $error("boot did not end after the second vector fetch");

    property p_r3;
        $past(!rst_b) |-> wait_primary == 3'h7 && wait_expansion == 3'h7;
    endproperty
    a_r3: assert property (p_r3)  // R3
        else $error("bus wait states not seven after reset");

    property p_r4;
        det != '0 |=> (pending & $past(det)) == $past(det);
    endproperty
    a_r4: assert property (p_r4)  // R4
        else $error("detected line did not become pending");

    property p_r6;
        take_vec != '0 |-> fetch_boundary && boot_done &&
                           (take_vec & ~pending) == '0 &&
                           (cpu_take & dma_take) == '0;
    endproperty
    a_r6: assert property (p_r6)  // R6
        else $error("interrupt taken away from a fetch boundary");

    property p_r8;
        det != '0 |=> (det & $past(det)) == '0;
    endproperty
    a_r8: assert property (p_r8)  // R8
        else $error("same line accepted on two adjacent edges");

    property p_r10;
        ack_decode_start |=> !interrupt_ack_strobe_b;
    endproperty
    a_r10: assert property (p_r10)  // R10
        else $error("ack strobe not low at decode");

    property p_r11;
        ack_read_start && !ack_decode_start |=> interrupt_ack_strobe_b;
    endproperty
    a_r11: assert property (p_r11)  // R11
        else $error("ack strobe not high at read");

    property p_r12;
        pending != '0 |=> (($past(pending) & ~$past(take_vec)) & ~pending)
                          == '0;
    endproperty
    a_r12: assert property (p_r12)  // R12
        else $error("pending flag lost without a take");

    c_take_cpu: cover property (cpu_take != '0);
    c_take_dma: cover property (dma_take != '0 && cpu_take != '0);
    c_ack:      cover property (ack_decode_start ##[1:4] ack_read_start);
    c_boot:     cover property ($rose(boot_done));

endmodule

// File: tb/eisa_irq_src.sv
`timescale 1ns/1ns
module eisa_irq_src (
    input  wire logic       clk_sys,
    input  wire logic [3:0] fire,
    input  wire logic [2:0] hold,
    output logic      [3:0] lines_b
);
    logic [2:0] cnt_r [4];

    initial begin
        for (int i = 0; i < 4; i++) cnt_r[i] = 3'h0;
    end

    // holds above two edges are only ever commanded to probe the holdoff
    always @(posedge clk_sys) begin
        for (int i = 0; i < 4; i++) begin
            if (fire[i]) begin
                cnt_r[i] <= hold;
            end else if (cnt_r[i] != 3'h0) begin
                cnt_r[i] <= cnt_r[i] - 3'h1;
            end
        end
    end

    // released lines return to the pulled-up idle level
    always_comb begin
        for (int i = 0; i < 4; i++) lines_b[i] = (cnt_r[i] == 3'h0);
    end
endmodule

// File: tb/test_ext_interrupt_sense_ack.sv
`timescale 1ns/1ns
module test_ext_interrupt_sense_ack;
    logic        clk_sys, rst_b, mode_mc, fb, vdone, ack_dec, ack_rd;
    logic        cfg_we, cfg_sel, strobe_b, vreq, bdone, clk_en;
    logic [3:0]  fire, cpu_en, dma_en, lines_b, cpu_take, dma_take, pending;
    logic [2:0]  hold, cfg_data, vwaits, wprim, wexp;
    logic [16:0] lf;
    int          bad_count, num_checks;
    int          got_cpu[4], got_dma[4], exp_cpu[4], exp_dma[4];

    eisa_irq_src src (.clk_sys(clk_sys), .fire(fire), .hold(hold),
                      .lines_b(lines_b));

    eisa_top dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
        .external_interrupt_lines_b(lines_b),
        .mode_microcomputer(mode_mc), .fetch_boundary(fb),
        .cpu_int_enable(cpu_en), .dma_int_enable(dma_en),
        .cpu_take(cpu_take), .dma_take(dma_take), .pending(pending),
        .ack_decode_start(ack_dec), .ack_read_start(ack_rd),
        .interrupt_ack_strobe_b(strobe_b), .vec_fetch_req(vreq),
        .vec_fetch_waits(vwaits), .vec_fetch_done(vdone),
        .boot_done(bdone), .wait_cfg_we(cfg_we), .wait_cfg_sel(cfg_sel),
        .wait_cfg_data(cfg_data), .wait_primary(wprim),
        .wait_expansion(wexp)
    );

    always #25 clk_sys = ~clk_sys;

    // ********************
    // helpers
    // ********************
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks=%0d bad=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic wait_for(input int which);
        for (int i = 0; i < 40; i++) begin
            @(negedge clk_sys);
            if ((which == 0 ? vreq : bdone) === 1'b1) return;
        end
        bad_count++;
        finish_test();
    endtask

    task automatic pulse_done;
        @(posedge clk_sys);
        vdone <= 1'b1;
        @(posedge clk_sys);
        vdone <= 1'b0;
    endtask

    // reset, then the two vector fetches of the chosen mode
    task automatic boot(input logic mc);
        @(posedge clk_sys);
        mode_mc <= mc;
        rst_b <= 1'b0;
        cyc(8);
        @(negedge clk_sys);
        check(pending, 8'h00);
        check(strobe_b, 8'h01);
        check(wprim, 8'h07);
        check(wexp, 8'h07);
        @(posedge clk_sys);
        rst_b <= 1'b1;
        wait_for(0);
        check(vwaits, mc ? 8'h00 : 8'h07);
        pulse_done();
        cyc(3);
        @(negedge clk_sys);
        check(bdone, 8'h00);
        pulse_done();
        wait_for(1);
        check(vreq, 8'h00);
    endtask

    always @(negedge clk_sys) begin
        for (int i = 0; i < 4; i++) begin
            if (cpu_take[i] === 1'b1) got_cpu[i]++;
            if (dma_take[i] === 1'b1) got_dma[i]++;
        end
    end

    // ********************
    // main sequence
    // ********************
    initial begin
        {clk_sys, rst_b, mode_mc, fb, vdone, ack_dec, ack_rd} = 7'h00;
        {cfg_we, cfg_sel, cfg_data, fire, cpu_en, dma_en} = 17'h00000;
        hold = 3'h1;
        clk_en = 1'b1;
        lf = 17'h12DAA;
        boot(1'b0);
        for (int s = 0; s < 2; s++) begin
            lf = lfsr(lf);
            @(posedge clk_sys);
            cfg_we <= 1'b1;
            cfg_sel <= s[0];
            cfg_data <= lf[2:0];
            @(posedge clk_sys);
            cfg_we <= 1'b0;
            @(negedge clk_sys);
            check(s ? wexp : wprim, {5'h00, lf[2:0]});
        end
        @(posedge clk_sys);
        ack_dec <= 1'b1;
        @(posedge clk_sys);
        ack_dec <= 1'b0;
        @(negedge clk_sys);
        check(strobe_b, 8'h00);
        cyc(3);
        @(negedge clk_sys);
        check(strobe_b, 8'h00);
        @(posedge clk_sys);
        ack_rd <= 1'b1;
        @(posedge clk_sys);
        ack_rd <= 1'b0;
        @(negedge clk_sys);
        check(strobe_b, 8'h01);
        // a decode arriving while the clock enable is low is not seen
        @(posedge clk_sys);
        clk_en <= 1'b0;
        ack_dec <= 1'b1;
        @(posedge clk_sys);
        ack_dec <= 1'b0;
        clk_en <= 1'b1;
        @(negedge clk_sys);
        check(strobe_b, 8'h01);
        // a detected request must wait for a fetch boundary
        @(posedge clk_sys);
        fire <= 4'h4;
        @(posedge clk_sys);
        fire <= 4'h0;
        cyc(8);
        @(negedge clk_sys);
        check(pending, 8'h04);
        cyc(10);
        @(negedge clk_sys);
        check(pending, 8'h04);
        @(posedge clk_sys);
        fb <= 1'b1;
        cpu_en <= 4'hF;
        exp_cpu[2] = 1;
        @(negedge clk_sys);
        check(cpu_take, 8'h04);
        @(posedge clk_sys);
        fb <= 1'b0;
        @(negedge clk_sys);
        check(pending, 8'h00);
        // every line, holds of one to four edges, core or dma taking
        @(posedge clk_sys);
        fb <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            for (int h = 1; h < 5; h++) begin
                lf = lfsr(lf);
                @(posedge clk_sys);
                fire <= 4'h1 << i;
                hold <= h[2:0];
                cpu_en <= {4{lf[0]}};
                dma_en <= {4{~lf[0]}};
                @(posedge clk_sys);
                fire <= 4'h0;
                cyc(10);
                if (lf[0]) exp_cpu[i] += (h < 3) ? 1 : 2;
                else exp_dma[i] += (h < 3) ? 1 : 2;
            end
        end
        for (int i = 0; i < 4; i++) begin
            check(8'(got_cpu[i]), 8'(exp_cpu[i]));
            check(8'(got_dma[i]), 8'(exp_dma[i]));
        end
        @(posedge clk_sys);
        fb <= 1'b0;
        boot(1'b1);
        finish_test();
    end
endmodule
